/* File: cif_pkg.sv */
// Purpose: constants for the interrupt flag block
// Assumes: 25 MHz ref_clk, 32-bit Avalon-MM slave
// Notes:   byte offsets are index * 4
package cif_pkg;

  // Source counts
  localparam int unsigned N_INT   = 15;
  localparam int unsigned N_EXT   = 4;
  localparam int unsigned N_HW    = N_INT + N_EXT;
  localparam int unsigned PRIO_W  = 3;
  localparam int unsigned N_ARCH  = 13;
  localparam int unsigned N_BREG  = 7;
  localparam int unsigned N_BANK  = 2;

  // Register indices, byte offset is index * 4
  localparam logic [3:0] IX_PC    = 4'h7;
  localparam logic [3:0] IX_INTB  = 4'h8;
  localparam logic [3:0] IX_USER_SP = 4'h9;
  localparam logic [3:0] IX_INTR_SP = 4'ha;
  localparam logic [3:0] IX_SB    = 4'hb;
  localparam logic [3:0] IX_FLG   = 4'hc;
  localparam logic [3:0] IX_SPACT = 4'hd;
  localparam logic [3:0] IX_SAVED = 4'he;
  localparam logic [3:0] IX_STAT  = 4'hf;

  // Flag register fields
  localparam int unsigned FLG_B   = 4;
  localparam int unsigned FLG_I   = 6;
  localparam int unsigned FLG_U   = 7;
  localparam int unsigned FLG_LVL = 12;
  localparam logic [15:0] FLG_WMASK = 16'h70ff;
  localparam logic [15:0] FLG_RST   = 16'h0000;

  // Largest INT number that switches to the interrupt stack
  localparam logic [5:0] INT_U_MAX = 6'h1f;

  // Software trap kinds, the four software sources
  typedef enum logic [1:0] {
    CIF_TRAP_UNDEF,
    CIF_TRAP_OVF,
    CIF_TRAP_BRK,
    CIF_TRAP_INT
  } cif_trap_t;

  // Bus answer state
  typedef enum logic {
    CIF_BUS_IDLE,
    CIF_BUS_ANS
  } cif_bus_t;

endpackage : cif_pkg

/* File: cif_arb.sv */
// Purpose: pick the highest priority pending hardware request
// Assumes: priorities packed, PRIO_W bits per source
// Notes:   ties go to the lowest source index
`timescale 1ns/10ps
module cif_arb #(
  parameter int unsigned N  = 19,
  parameter int unsigned PW = 3,
  parameter int unsigned IW = 5
) (
  input  wire logic [N-1:0]    req,
  input  wire logic [N*PW-1:0] prio,
  output logic                 best_vld,
  output logic [IW-1:0]        best_idx,
  output logic [PW-1:0]        best_prio
);

  // Priority slice of one source
  function automatic logic [PW-1:0] prio_of(
    input logic [N*PW-1:0] v,
    input int unsigned     i
  );
    prio_of = v[i*PW +: PW];
  endfunction : prio_of

  // Strictly greater keeps the lowest index on ties
  always_comb begin
    best_vld  = 1'b0;
    best_idx  = '0;
    best_prio = '0;
    for (int unsigned i = 0; i < N; i++) begin
      if (req[i] && (!best_vld || prio_of(prio, i) > best_prio)) begin
        best_vld  = 1'b1;
        best_idx  = IW'(i);
        best_prio = prio_of(prio, i);
      end
    end
  end

endmodule : cif_arb

/* File: cif_flags.sv */
// Purpose: processor flag logic, bank storage and interrupt accept
// Assumes: requests and traps synchronous to ref_clk
// Notes:   all state lives in one packed struct
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module cif_flags #(
  parameter int unsigned N_INT = cif_pkg::N_INT,
  parameter int unsigned N_EXT = cif_pkg::N_EXT
) (
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  input  wire logic [5:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic [N_INT+N_EXT-1:0] hw_req,
  input  wire logic [(N_INT+N_EXT)*3-1:0] hw_prio,
  input  wire logic                  trap_req,
  input  wire logic [1:0]            trap_kind,
  input  wire logic [5:0]            trap_num,
  input  wire logic                  flag_restore,
  output logic                       ack_valid,
  output logic                       ack_is_hw,
  output logic [4:0]                 ack_src,
  output logic [5:0]                 ack_trap_num,
  output logic                       int_enable,
  output logic                       stack_sel,
  output logic [2:0]                 processor_priority_level,
  output logic                       bank_sel,
  output logic [15:0]                active_sp
);

  localparam int unsigned NH = N_INT + N_EXT;
  localparam int unsigned PW = cif_pkg::PRIO_W;

  // Whole block state, one register
  typedef struct packed {
    cif_pkg::cif_bus_t          bus;   // Bus answer phase
    logic                       wreq;  // Waitrequest
    logic [31:0]                rdata; // Latched read data
    logic [1:0][6:0][15:0]      bank;  // Two register banks
    logic [19:0]                pc;    // Program counter
    logic [19:0]                intb;  // Vector table base
    logic [15:0]                user_stack_pointer;      // User stack pointer
    logic [15:0]                interrupt_stack_pointer; // Interrupt stack pointer
    logic [15:0]                sb;    // Static base
    logic [15:0]                flg;   // Flag register
    logic [15:0]                saved; // Flags before last accept
    logic                       ackv;  // Acknowledge pulse
    logic                       ackhw; // Acknowledge was hardware
    logic [4:0]                 asrc;  // Hardware source index
    logic [5:0]                 anum;  // Trap number
    logic [15:0]                sp;    // Active stack pointer
  } cif_state_t;

  cif_state_t s_q;                     // Registered state
  cif_state_t s_d;                     // Next state

  logic          arb_vld;              // Some request pending
  logic [4:0]    arb_idx;              // Winning source
  logic [PW-1:0] arb_prio;             // Winning priority
  logic [3:0]    idx;                  // Word index of access
  logic [2:0]    cur_lvl;              // Current level
  logic          take_hw;              // Hardware accept now
  logic          u_clr_trap;           // Trap that clears U

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] be_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0]  be
  );
    be_merge = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        be_merge[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
  endfunction : be_merge

  // Priority arbitration across the maskable sources
  cif_arb #(
    .N  (NH),
    .PW (PW),
    .IW (5)
  ) u_arb (
    .req       (hw_req),
    .prio      (hw_prio),
    .best_vld  (arb_vld),
    .best_idx  (arb_idx),
    .best_prio (arb_prio)
  );

  assign idx   = avs_address[5:2];
  assign cur_lvl = s_q.flg[cif_pkg::FLG_LVL +: 3];

  // Maskable accept needs enable set and strictly higher priority
  assign take_hw = arb_vld && s_q.flg[cif_pkg::FLG_I]
                && (arb_prio > cur_lvl) && !trap_req;

  // Of the traps, only INT with a small number moves to the interrupt stack
  assign u_clr_trap = (trap_kind == cif_pkg::CIF_TRAP_INT)
                   && (trap_num <= cif_pkg::INT_U_MAX);

  // Next-state logic: bus, restore, then acceptance
  always_comb begin
    logic [31:0] rd_v;
    logic [31:0] wv;
    logic        bsel;
    rd_v = '0;
    wv   = '0;
    bsel = s_q.flg[cif_pkg::FLG_B];
    s_d      = s_q;
    s_d.ackv = 1'b0;

    // Read mux over the thirteen registers plus status words
    if (idx < 4'(cif_pkg::N_BREG)) begin
      rd_v = {16'h0000, s_q.bank[bsel][idx[2:0]]};
    end else begin
      unique case (idx)
        cif_pkg::IX_PC:    rd_v = {12'h000, s_q.pc};
        cif_pkg::IX_INTB:  rd_v = {12'h000, s_q.intb};
        cif_pkg::IX_USER_SP: rd_v = {16'h0000, s_q.user_stack_pointer};
        cif_pkg::IX_INTR_SP: rd_v = {16'h0000, s_q.interrupt_stack_pointer};
        cif_pkg::IX_SB:    rd_v = {16'h0000, s_q.sb};
        // Reserved flag bits come back as zero
        cif_pkg::IX_FLG:   rd_v = {16'h0000, s_q.flg & cif_pkg::FLG_WMASK};
        cif_pkg::IX_SPACT: rd_v = {16'h0000, s_q.sp};
        cif_pkg::IX_SAVED: rd_v = {16'h0000, s_q.saved};
        cif_pkg::IX_STAT:  rd_v = {20'h00000, arb_vld, arb_prio, 3'h0, arb_idx};
        default:           rd_v = '0;
      endcase
    end
    wv = be_merge(rd_v, avs_writedata, avs_byteenable);

    // Two-phase answer: request seen, then answered one cycle later
    unique case (s_q.bus)
      cif_pkg::CIF_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          s_d.bus   = cif_pkg::CIF_BUS_ANS;
          s_d.wreq  = 1'b0;
          s_d.rdata = avs_read ? rd_v : 32'h0000_0000;
        end
      end
      cif_pkg::CIF_BUS_ANS: begin
        s_d.bus  = cif_pkg::CIF_BUS_IDLE;
        s_d.wreq = 1'b1;
        // The write lands on the edge that sees waitrequest low
        if (avs_write) begin
          if (idx < 4'(cif_pkg::N_BREG)) begin
            s_d.bank[bsel][idx[2:0]] = wv[15:0];
          end else begin
            unique case (idx)
              cif_pkg::IX_PC:    s_d.pc    = wv[19:0];
              cif_pkg::IX_INTB:  s_d.intb  = wv[19:0];
              cif_pkg::IX_USER_SP: s_d.user_stack_pointer      = wv[15:0];
              cif_pkg::IX_INTR_SP: s_d.interrupt_stack_pointer = wv[15:0];
              cif_pkg::IX_SB:    s_d.sb    = wv[15:0];
              // Reserved bits are held at zero whatever is written
              cif_pkg::IX_FLG:   s_d.flg   = wv[15:0] & cif_pkg::FLG_WMASK;
              cif_pkg::IX_SPACT: begin
                if (s_q.flg[cif_pkg::FLG_U]) begin
                  s_d.user_stack_pointer = wv[15:0];
                end else begin
                  s_d.interrupt_stack_pointer = wv[15:0];
                end
              end
              cif_pkg::IX_SAVED: s_d.saved = wv[15:0] & cif_pkg::FLG_WMASK;
              default:           s_d.flg   = s_d.flg; // Status is read only
            endcase
          end
        end
      end
    endcase

    // Return from handler brings the saved flags back
    if (flag_restore) begin
      s_d.flg = s_q.saved;
    end

    // Acceptance wins over a software write in the same cycle so
    // the handler never starts with interrupts still enabled
    if (trap_req) begin
      s_d.saved                 = s_q.flg;
      s_d.flg[cif_pkg::FLG_I]   = 1'b0;
      if (u_clr_trap) begin
        s_d.flg[cif_pkg::FLG_U] = 1'b0;
      end
      s_d.ackv  = 1'b1;
      s_d.ackhw = 1'b0;
      s_d.anum  = trap_num;
    end else if (take_hw) begin
      s_d.saved                      = s_q.flg;
      s_d.flg[cif_pkg::FLG_I]        = 1'b0;
      s_d.flg[cif_pkg::FLG_U]        = 1'b0;
      s_d.flg[cif_pkg::FLG_LVL +: 3] = arb_prio;
      s_d.ackv  = 1'b1;
      s_d.ackhw = 1'b1;
      s_d.asrc  = arb_idx;
    end

    // Active stack pointer follows the next flag value
    s_d.sp = s_d.flg[cif_pkg::FLG_U] ? s_d.user_stack_pointer
           : s_d.interrupt_stack_pointer;
  end

  // State register; waitrequest idles high
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q       <= '0;
      s_q.bus   <= cif_pkg::CIF_BUS_IDLE;
      s_q.wreq  <= 1'b1;
      s_q.flg   <= cif_pkg::FLG_RST;
      s_q.saved <= cif_pkg::FLG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state flops
  assign avs_readdata    = s_q.rdata;
  assign avs_waitrequest = s_q.wreq;
  assign ack_valid       = s_q.ackv;
  assign ack_is_hw       = s_q.ackhw;
  assign ack_src         = s_q.asrc;
  assign ack_trap_num    = s_q.anum;
  assign int_enable      = s_q.flg[cif_pkg::FLG_I];
  assign stack_sel       = s_q.flg[cif_pkg::FLG_U];
  assign processor_priority_level = cur_lvl;
  assign bank_sel        = s_q.flg[cif_pkg::FLG_B];
  assign active_sp       = s_q.sp;

  // Checks on the logic above
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // Flag word read back shows the stored flags
  a_flg_read_back: assert property (
    (s_q.bus == cif_pkg::CIF_BUS_IDLE) && avs_read
      && (idx == cif_pkg::IX_FLG)
    |=> avs_readdata[15:0] == ($past(s_q.flg) & cif_pkg::FLG_WMASK)
  ) else $error("flag read returned wrong value");

  // Bank write lands in the bank the flag selected
  a_bank_write: assert property (
    (s_q.bus == cif_pkg::CIF_BUS_ANS) && avs_write
      && (idx == 4'h0) && (avs_byteenable == 4'hf)
    |=> s_q.bank[$past(bank_sel)][0] == $past(avs_writedata[15:0])
  ) else $error("bank register write lost");

  // No hardware acknowledge while interrupts are disabled
  a_mask_block: assert property (
    !int_enable |=> !(ack_valid && ack_is_hw)
  ) else $error("hardware accept with enable clear");

  // Every acknowledge shows enable cleared at once
  a_ack_clr_ie: assert property (
    ack_valid |-> !int_enable
  ) else $error("enable still set at acknowledge");

  // Active stack pointer tracks the select flag
  a_sp_select: assert property (
    active_sp == (stack_sel ? s_q.user_stack_pointer : s_q.interrupt_stack_pointer)
  ) else $error("wrong stack pointer selected");

  // High trap numbers keep the stack select
  a_trap_keep_u: assert property (
    trap_req && !u_clr_trap && !flag_restore
      && !((s_q.bus == cif_pkg::CIF_BUS_ANS) && avs_write)
    |=> stack_sel == $past(stack_sel)
  ) else $error("stack select changed by high trap");

  // Hardware accept raises the level to the source priority
  a_level_update: assert property (
    take_hw |=> ack_valid && ack_is_hw && (processor_priority_level == $past(arb_prio))
      && !stack_sel
  ) else $error("level or stack select wrong after accept");

  // Accepted priority was strictly above the level before
  a_prio_strict: assert property (
    ack_valid && ack_is_hw
    |-> $past(arb_prio) > $past(cur_lvl)
  ) else $error("request accepted without higher priority");

  // Reserved flag bits never hold a one
  a_rsv_zero: assert property (
    (s_q.flg & ~cif_pkg::FLG_WMASK) == 16'h0000
  ) else $error("reserved flag bit set");

  // Hardware source index stays inside the source count
  a_src_range: assert property (
    ack_valid && ack_is_hw |-> ack_src < 5'(NH)
  ) else $error("acknowledge source out of range");

  // Enabled, higher request is taken in the next cycle
  a_take_next: assert property (
    int_enable && arb_vld && (arb_prio > processor_priority_level) && !trap_req
    |=> (ack_valid && ack_is_hw) ##1 !(ack_valid && ack_is_hw)
  ) else $error("eligible request not taken in one cycle");

endmodule : cif_flags

/* File: cif_src_model.sv */
// Purpose: far-side model of the request sources and the sequencer
// Assumes: bench commands arrive as one-cycle pulses after a rising edge
// Notes:   trap fields wander between traps so stale values never help
`timescale 1ns/10ps
module cif_src_model (
  input  wire logic                         ref_clk,    // CPU clock
  input  wire logic                         arst_n,     // Async reset, low
  input  wire logic                         raise,      // Raise one source
  input  wire logic [4:0]                   raise_idx,  // Source to raise
  input  wire logic [2:0]                   raise_prio, // Its priority
  input  wire logic                         trap_go,    // Sequencer runs a trap
  input  wire logic [1:0]                   cmd_kind,   // Kind of that trap
  input  wire logic [5:0]                   cmd_num,    // Number of that trap
  input  wire logic                         restore_go, // Return from handler
  input  wire logic                         ack_valid,  // Acceptance pulse
  input  wire logic                         ack_is_hw,  // Hardware acceptance
  input  wire logic [4:0]                   ack_src,    // Accepted source
  output logic [cif_pkg::N_HW-1:0]          hw_req,     // Level requests
  output logic [cif_pkg::N_HW*3-1:0]        hw_prio,    // Three bits a source
  output logic                              trap_req,   // Trap pulse
  output logic [1:0]                        trap_kind,  // Trap kind
  output logic [5:0]                        trap_num,   // Trap number
  output logic                              flag_restore // Restore pulse
);
  // Each source holds its level until its own acceptance comes back
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hw_req       <= '0;
      hw_prio      <= '0;
      trap_req     <= 1'h0;
      trap_kind    <= 2'h0;
      trap_num     <= 6'h00;
      flag_restore <= 1'h0;
    end else begin
      // Accepted source drops, others keep waiting
      if (ack_valid && ack_is_hw) begin
        hw_req[ack_src] <= 1'h0;
      end
      // Any of the nineteen sources may be raised with its level
      if (raise) begin
        hw_req[raise_idx]          <= 1'h1;
        hw_prio[raise_idx*3 +: 3]  <= raise_prio;
      end
      trap_req     <= trap_go;
      flag_restore <= restore_go;
      // Outside a trap the fields change every cycle, not hold
      trap_kind    <= trap_go ? cmd_kind : ~trap_kind;
      trap_num     <= trap_go ? cmd_num : ~trap_num;
    end
  end
endmodule : cif_src_model

/* File: cpu_interrupt_flag_logic_test.sv */
// Purpose: self-checking bench for the processor flag block
// Assumes: one 25 MHz clock, Avalon-MM master with waitrequest
// Notes:   a small model of flags and banks predicts every result
`timescale 1ns/10ps
module cpu_interrupt_flag_logic_test;
  logic        ref_clk        = 1'h0;   // Bench clock, 40 ns period
  logic        arst_n         = 1'h0;   // Reset, low at start
  logic [5:0]  avs_address    = 6'h00;  // Bus master signals
  logic        avs_read       = 1'h0;
  logic        avs_write      = 1'h0;
  logic [31:0] avs_writedata  = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;   // Whole words only
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        raise          = 1'h0;   // Commands to the source model
  logic [4:0]  raise_idx      = 5'h00;
  logic [2:0]  raise_prio     = 3'h0;
  logic        trap_go        = 1'h0;
  logic [1:0]  cmd_kind       = 2'h0;
  logic [5:0]  cmd_num        = 6'h00;
  logic        restore_go     = 1'h0;
  logic [cif_pkg::N_HW-1:0]   hw_req;   // Model to design
  logic [cif_pkg::N_HW*3-1:0] hw_prio;
  logic        trap_req, flag_restore, ack_valid, ack_is_hw;
  logic        int_enable, stack_sel, bank_sel;
  logic [1:0]  trap_kind;
  logic [5:0]  trap_num, ack_trap_num;
  logic [4:0]  ack_src;
  logic [2:0]  processor_priority_level;
  logic [15:0] active_sp, fl, sv, va, vb; // Expected flags, saved flags
  logic [15:0] bk [2][7];               // Expected bank contents
  logic [31:0] rd;                      // Last read data
  int          n_errors, cmp_count, s, k, b;
  integer      seed = 32'h37e9120d;

  // Free-running clock
  always #20 ref_clk = ~ref_clk;

  cif_src_model src (.ref_clk(ref_clk), .arst_n(arst_n), .raise(raise),
    .raise_idx(raise_idx), .raise_prio(raise_prio), .trap_go(trap_go),
    .cmd_kind(cmd_kind), .cmd_num(cmd_num), .restore_go(restore_go),
    .ack_valid(ack_valid), .ack_is_hw(ack_is_hw), .ack_src(ack_src), .hw_req(hw_req),
    .hw_prio(hw_prio), .trap_req(trap_req), .trap_kind(trap_kind),
    .trap_num(trap_num), .flag_restore(flag_restore));

  cif_flags dut (.ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hw_req(hw_req), .hw_prio(hw_prio),
    .trap_req(trap_req), .trap_kind(trap_kind), .trap_num(trap_num),
    .flag_restore(flag_restore), .ack_valid(ack_valid), .ack_is_hw(ack_is_hw),
    .ack_src(ack_src), .ack_trap_num(ack_trap_num), .int_enable(int_enable),
    .stack_sel(stack_sel), .bank_sel(bank_sel),
    .processor_priority_level(processor_priority_level),
    .active_sp(active_sp));

  // Verdict and end of run, also reached by any expired wait
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // One comparison, four-state exact
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : chk

  // One bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] ix, input logic [31:0] wd);
    int i;
    @(posedge ref_clk);
    avs_address   <= {ix, 2'h0};
    avs_write     <= w;
    avs_read      <= ~w;
    avs_writedata <= wd;
    for (i = 0; i < 20 && avs_waitrequest !== 1'h0; i++) @(posedge ref_clk);
    if (i == 20) begin
      n_errors++;
      close_out();
    end
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read  <= 1'h0;
  endtask : bus

  task automatic rdchk(input logic [3:0] ix, input logic [31:0] exp, input logic [31:0] m);
    bus(1'h0, ix, 32'h0);
    chk(rd & m, exp & m);
  endtask : rdchk

  // Flag outputs against the model
  task automatic flagchk;
    chk(int_enable, fl[6]);
    chk(stack_sel, fl[7]);
    chk(processor_priority_level, fl[14:12]);
    chk(bank_sel, fl[4]);
  endtask : flagchk

  // Reserved flag bits are always written as zero
  task automatic setfl(input logic [15:0] v);
    fl = v & 16'h70ff;
    bus(1'h1, cif_pkg::IX_FLG, {16'h0, fl});
    @(negedge ref_clk);
    flagchk();
  endtask : setfl

  task automatic wait_ack;
    int i;
    for (i = 0; i < 20; i++) begin
      @(negedge ref_clk);
      if (ack_valid === 1'h1) break;
    end
    if (i == 20) begin
      n_errors++;
      close_out();
    end
  endtask : wait_ack

  // Hardware acceptance: enable and stack flag cleared, level taken
  task automatic hw_ack(input logic [4:0] src_i, input logic [2:0] p);
    sv = fl;
    fl[6] = 1'h0;
    fl[7] = 1'h0;
    fl[14:12] = p;
    wait_ack();
    chk(ack_is_hw, 1'h1);
    chk(ack_src, src_i);
    chk(int_enable, 1'h0);
    chk(stack_sel, 1'h0);
    flagchk();
  endtask : hw_ack

  task automatic no_ack;
    repeat (10) begin
      @(negedge ref_clk);
      chk(ack_valid, 1'h0);
    end
  endtask : no_ack

  task automatic pulse_src(input logic [4:0] i, input logic [2:0] p);
    @(posedge ref_clk);
    raise      <= 1'h1;
    raise_idx  <= i;
    raise_prio <= p;
    @(posedge ref_clk);
    raise      <= 1'h0;
  endtask : pulse_src

  // Hang guard
  initial begin
    #2000000;
    n_errors++;
    close_out();
  end

  initial begin
    fl = 16'h0;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'h1;
    @(negedge ref_clk);
    flagchk();
    rdchk(cif_pkg::IX_FLG, 32'h0, 32'h70ff);
    // Masked source waits, then wins once enabled
    pulse_src(5'h03, 3'h5);
    setfl(16'h2080);
    no_ack();
    setfl(16'h20c0);
    hw_ack(5'h03, 3'h5);
    // Saved word holds the flags from before the accept
    rdchk(cif_pkg::IX_SAVED, {16'h0, sv}, 32'h70ff);
    // Return from handler brings the old flags back
    @(posedge ref_clk);
    restore_go <= 1'h1;
    @(posedge ref_clk);
    restore_go <= 1'h0;
    repeat (2) @(negedge ref_clk);
    fl = sv;
    flagchk();
    // Equal level waits, higher level overtakes it
    pulse_src(5'h07, 3'h2);
    no_ack();
    // Status shows the waiting source: pending, level 2, index 7
    rdchk(cif_pkg::IX_STAT, 32'h0000_0a07, 32'h0000_0f1f);
    pulse_src(5'h12, 3'h3);
    hw_ack(5'h12, 3'h3);
    setfl(16'h0040);
    hw_ack(5'h07, 3'h2);
    // Every hardware source, random level above zero
    for (s = 0; s < cif_pkg::N_HW; s++) begin
      k = $unsigned($random(seed)) % 7 + 1;
      pulse_src(s[4:0], k[2:0]);
      setfl(16'h0040 | ($random(seed) & 16'h003f));
      hw_ack(s[4:0], k[2:0]);
    end
    // All trap kinds, numbers either side of the stack boundary
    for (k = 0; k < 8; k++) begin
      setfl(16'h30c0);
      @(posedge ref_clk);
      trap_go  <= 1'h1;
      cmd_kind <= k[1:0];
      cmd_num  <= (k < 4) ? 6'h1f : 6'h20;
      @(posedge ref_clk);
      trap_go  <= 1'h0;
      fl[6] = 1'h0;
      if (k == 3) fl[7] = 1'h0;
      wait_ack();
      chk(ack_is_hw, 1'h0);
      chk(ack_trap_num, (k < 4) ? 6'h1f : 6'h20);
      flagchk();
    end
    // Stack pointer choice follows the stack flag
    va = $random(seed);
    vb = $random(seed);
    bus(1'h1, cif_pkg::IX_USER_SP, {16'h0, va});
    bus(1'h1, cif_pkg::IX_INTR_SP, {16'h0, vb});
    setfl(16'h0080);
    chk(active_sp, va);
    rdchk(cif_pkg::IX_SPACT, {16'h0, va}, 32'hffff);
    setfl(16'h0000);
    chk(active_sp, vb);
    // Two banks, each kept apart
    for (b = 0; b < 2; b++) begin
      setfl(b ? 16'h0010 : 16'h0000);
      for (k = 0; k < 7; k++) begin
        bk[b][k] = $random(seed);
        bus(1'h1, k[3:0], {16'h0, bk[b][k]});
      end
    end
    for (b = 0; b < 2; b++) begin
      setfl(b ? 16'h0010 : 16'h0000);
      for (k = 0; k < 7; k++) rdchk(k[3:0], {16'h0, bk[b][k]}, 32'hffff);
    end
    // Remaining programmer registers hold what was written
    for (k = 7; k < 12; k++) begin
      va = $random(seed);
      bus(1'h1, k[3:0], {16'h0, va});
      rdchk(k[3:0], {16'h0, va}, 32'hffff);
    end
    // Read-only status ignores writes and shows nothing pending
    bus(1'h1, cif_pkg::IX_STAT, 32'hffffffff);
    rdchk(cif_pkg::IX_STAT, 32'h0, 32'h0800);
    rdchk(cif_pkg::IX_FLG, {16'h0, fl}, 32'h70ff);
    close_out();
  end
endmodule : cpu_interrupt_flag_logic_test
